// File: rtl/ebad_cfg.svh
/*
 * constants for the external bus area decoder: register offsets,
 * field positions, reset values and refresh register passwords.
 * assumes inclusion by bare name from design and testbench files.
 */
`ifndef EBAD_CFG_SVH
`define EBAD_CFG_SVH

`define EBAD_OFF_PARITY_CTRL 4'h0
`define EBAD_OFF_REFRESH_CTRL 4'h1
`define EBAD_OFF_REFRESH_TCS 4'h2
`define EBAD_OFF_REFRESH_CNT 4'h3
`define EBAD_OFF_REFRESH_CONST 4'h4
`define EBAD_OFF_BUS_CTRL 4'h5

`define EBAD_PAR_ERR_BIT 15
`define EBAD_PAR_FORCE_BIT 14
`define EBAD_PAR_POL_BIT 13
`define EBAD_PAR_SEL_HI_BIT 12
`define EBAD_PAR_SEL_LO_BIT 11

`define EBAD_BCR_DRAM_BIT 15
`define EBAD_BCR_MUXIO_BIT 14

`define EBAD_PCR_RESET 16'h0000
`define EBAD_BCR_RESET 16'h0000
`define EBAD_RCR_RESET 8'h00
`define EBAD_REFRESH_TIMER_CTRL_STATUS_RESET 8'h00
`define EBAD_REFRESH_COUNTER_REG_RESET 8'h00
`define EBAD_REFRESH_CONSTANT_REG_RESET 8'hFF

`define EBAD_PW_RCR 8'h5A
`define EBAD_PW_REFRESH_TIMER_CTRL_STATUS 8'hA5
`define EBAD_PW_REFRESH_COUNTER_REG 8'h69
`define EBAD_PW_REFRESH_CONSTANT_REG 8'h96

`endif

// File: rtl/ebad_pkg.sv
/*
 * types for the external bus area decoder.
 * assumes nothing beyond a systemverilog compiler.
 */
package ebad_pkg;

  typedef enum logic [1:0] {
    ebad_size_byte = 2'h0,
    ebad_size_word = 2'h1,
    ebad_size_long = 2'h2
  } ebad_size_t;

  typedef enum logic [1:0] {
    ebad_width_8 = 2'h0,
    ebad_width_16 = 2'h1,
    ebad_width_32 = 2'h2
  } ebad_width_t;

  typedef enum logic [2:0] {
    ebad_idle = 3'b001,
    ebad_busy = 3'b010,
    ebad_done = 3'b100
  } ebad_state_t;

  // cpu access request
  typedef struct packed {
    logic valid;
    logic write;
    ebad_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ebad_req_t;

  // one external bus cycle
  typedef struct packed {
    logic active;
    logic write;
    logic [27:0] addr;
    logic [15:0] data;
    logic [7:0] cs_n;
    logic dram;
    logic muxio;
  } ebad_cyc_t;

  // register port
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic word;
    logic hi_lane;
  } ebad_reg_t;

endpackage : ebad_pkg

// File: rtl/ebad_top.sv
/*
 * external bus area decoder: area decode, chip selects, bus width
 * choice, splitting of wide accesses, parity and protected refresh
 * registers.
 * assumes a cpu that holds its request until done, a register master
 * that reads data one cycle after the read strobe, and external
 * memories that return read data in the same cycle as the bus cycle.
 */
// The implementer's own choices: the strobed register port and the address map.
// Overview of operation
// - parity error flag: set on error, read-then-zero clears
// - force bit drives both parity pins high
// - polarity bit: 0 even, 1 odd
// - space field: none, dram, dram plus area2
// - parity control low eleven bits read zero
// - refresh registers written only by word
// - password in upper byte, data lower
// - wrong password discards the whole write
// - refresh registers word read upper byte zero
// - top four address bits ignored, not driven
// - bit 27 picks 8 or 16 bit by default
// - bits 26 to 24 decode eight areas
// - area 0 width from boot mode pins
// - area 5 low half on-chip modules, bit 8 width
// - area 6 width from bit 14 or bit 27
// - area 6 low half muxed io when enabled
// - area 7: on-chip ram or 8-bit external
// - area 1 dram when dram enable set
// - wide accesses split into two or four cycles
// - 16-bit bus byte lanes by address
// - only the decoded chip select goes low
// - no chip select for on-chip spaces
`timescale 1ns/1ps
`include "ebad_cfg.svh"

module ebad_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] boot_mode_pins,
  input wire ebad_pkg::ebad_req_t cpu_req,
  output logic cpu_done,
  output logic [31:0] cpu_rdata,
  output logic cpu_onchip,
  output ebad_pkg::ebad_cyc_t bus_cyc,
  output logic [15:0] addr_data_pins_o,
  output logic [15:0] addr_data_pins_oe,
  input wire logic [15:0] addr_data_pins_i,
  output logic [7:0] area_select_n,
  output logic parity_pin_high_o,
  output logic parity_pin_low_o,
  output logic parity_pins_oe,
  input wire logic parity_pin_high_i,
  input wire logic parity_pin_low_i,
  input wire ebad_pkg::ebad_reg_t reg_bus,
  output logic [15:0] reg_rdata
);

  logic [15:0] bus_control_reg;
  logic parity_error_flag;
  logic parity_force_high;
  logic parity_polarity;
  logic parity_space_sel_hi;
  logic parity_space_sel_lo;
  logic pef_seen;
  logic [7:0] refresh_control_reg;
  logic [7:0] refresh_timer_ctrl_status;
  logic [7:0] refresh_counter_reg;
  logic [7:0] refresh_constant_reg;
  ebad_pkg::ebad_state_t state;
  logic [1:0] beat;
  logic [1:0] next_beat;
  logic [31:0] rbuf;
  logic [2:0] area;
  ebad_pkg::ebad_width_t width;
  logic external;
  logic is_dram;
  logic is_muxio;
  logic [1:0] beats_m1;
  logic [27:0] beat_addr;
  logic [15:0] beat_data;
  logic [1:0] lane;
  logic par_check;
  logic par_err;
  logic [15:0] pcr_value;
  logic wr_word_ok;

  // parity of one byte under current polarity
  function automatic logic lane_parity(input logic [7:0] b, input logic odd);
    lane_parity = (^b) ^ odd;
  endfunction : lane_parity

  // byte of a 32-bit word by byte index
  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0] i);
    pick_byte = w[8*(3-i) +: 8];
  endfunction : pick_byte

  // area decode and width selection
  always_comb begin
    area = cpu_req.addr[26:24];
    width = cpu_req.addr[27] ? ebad_pkg::ebad_width_16
                             : ebad_pkg::ebad_width_8;
    external = 1'b1;
    is_dram = 1'b0;
    is_muxio = 1'b0;
    unique case (area)
      3'h0: begin
        unique case (boot_mode_pins)
          3'b001: width = ebad_pkg::ebad_width_16;
          3'b010: begin
            width = ebad_pkg::ebad_width_32;
            external = 1'b0;
          end
          default: width = ebad_pkg::ebad_width_8;
        endcase
      end
      3'h1: is_dram = bus_control_reg[`EBAD_BCR_DRAM_BIT];
      3'h5: begin
        if (!cpu_req.addr[27]) begin
          external = 1'b0;
          width = cpu_req.addr[8] ? ebad_pkg::ebad_width_16
                                  : ebad_pkg::ebad_width_8;
        end
      end
      3'h6: begin
        if (!cpu_req.addr[27]) begin
          width = cpu_req.addr[14] ? ebad_pkg::ebad_width_16
                                   : ebad_pkg::ebad_width_8;
          is_muxio = bus_control_reg[`EBAD_BCR_MUXIO_BIT];
        end
      end
      3'h7: begin
        if (cpu_req.addr[27]) begin
          width = ebad_pkg::ebad_width_32;
          external = 1'b0;
        end
      end
      default: ;
    endcase
  end

  // beats needed for this access on this width
  always_comb begin
    beats_m1 = 2'h0;
    if (width == ebad_pkg::ebad_width_8) begin
      if (cpu_req.size == ebad_pkg::ebad_size_word) beats_m1 = 2'h1;
      if (cpu_req.size == ebad_pkg::ebad_size_long) beats_m1 = 2'h3;
    end else if (width == ebad_pkg::ebad_width_16) begin
      if (cpu_req.size == ebad_pkg::ebad_size_long) beats_m1 = 2'h1;
    end
  end

  // index of the beat launched at the coming edge
  always_comb begin
    next_beat = 2'h0;
    if (state == ebad_pkg::ebad_busy) next_beat = beat + 2'h1;
  end

  // address and write data of the beat being launched
  always_comb begin
    beat_addr = cpu_req.addr[27:0];
    beat_data = 16'h0000;
    lane = 2'h3;
    if (width == ebad_pkg::ebad_width_8) begin
      beat_addr = cpu_req.addr[27:0] + {26'h0, next_beat};
      if (cpu_req.size == ebad_pkg::ebad_size_long) begin
        lane = next_beat;
      end else if (cpu_req.size == ebad_pkg::ebad_size_word) begin
        lane = {1'b1, next_beat[0]};
      end
      beat_data = {8'h00, pick_byte(cpu_req.wdata, lane)};
    end else begin
      beat_addr = cpu_req.addr[27:0] + {25'h0, next_beat, 1'b0};
      if (cpu_req.size == ebad_pkg::ebad_size_byte) begin
        if (cpu_req.addr[0]) beat_data = {8'h00, cpu_req.wdata[7:0]};
        else beat_data = {cpu_req.wdata[7:0], 8'h00};
      end else if (cpu_req.size == ebad_pkg::ebad_size_word) begin
        beat_data = cpu_req.wdata[15:0];
      end else begin
        beat_data = next_beat[0] ? cpu_req.wdata[15:0]
                                 : cpu_req.wdata[31:16];
      end
    end
  end

  // sequencing of bus beats
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ebad_pkg::ebad_idle;
      beat <= 2'h0;
    end else begin
      unique case (state)
        ebad_pkg::ebad_idle: begin
          beat <= 2'h0;
          if (cpu_req.valid) state <= ebad_pkg::ebad_busy;
        end
        ebad_pkg::ebad_busy: begin
          if (!external || beat == beats_m1) state <= ebad_pkg::ebad_done;
          else beat <= beat + 2'h1;
        end
        ebad_pkg::ebad_done: begin
          beat <= 2'h0;
          state <= ebad_pkg::ebad_idle;
        end
        default: state <= ebad_pkg::ebad_idle;
      endcase
    end
  end

  assign cpu_done = (state == ebad_pkg::ebad_done);
  assign cpu_onchip = (state == ebad_pkg::ebad_busy) && !external;

  // bus cycle outputs, registered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_cyc <= '0;
      area_select_n <= 8'hFF;
      addr_data_pins_o <= 16'h0000;
      addr_data_pins_oe <= 16'h0000;
      parity_pin_high_o <= 1'b0;
      parity_pin_low_o <= 1'b0;
      parity_pins_oe <= 1'b0;
    end else begin
      bus_cyc <= '0;
      area_select_n <= 8'hFF;
      addr_data_pins_oe <= 16'h0000;
      parity_pins_oe <= 1'b0;
      if (state != ebad_pkg::ebad_done && cpu_req.valid && external &&
          !(state == ebad_pkg::ebad_busy && beat == beats_m1) ) begin
        bus_cyc.active <= 1'b1;
        bus_cyc.write <= cpu_req.write;
        bus_cyc.addr <= beat_addr;
        bus_cyc.data <= beat_data;
        bus_cyc.dram <= is_dram;
        bus_cyc.muxio <= is_muxio;
        if (!is_dram) area_select_n <= ~(8'h01 << area);
        bus_cyc.cs_n <= is_dram ? 8'hFF : ~(8'h01 << area);
        addr_data_pins_o <= beat_data;
        if (cpu_req.write) begin
          addr_data_pins_oe <= (width == ebad_pkg::ebad_width_8) ?
                               16'h00FF : 16'hFFFF;
          parity_pins_oe <= par_check;
          parity_pin_high_o <= parity_force_high |
                               lane_parity(beat_data[15:8], parity_polarity);
          parity_pin_low_o <= parity_force_high |
                              lane_parity(beat_data[7:0], parity_polarity);
        end
      end
    end
  end

  // parity space selection
  always_comb begin
    par_check = 1'b0;
    unique case ({parity_space_sel_hi, parity_space_sel_lo})
      2'b01: par_check = is_dram;
      2'b10: par_check = is_dram || (area == 3'h2 && external);
      default: par_check = 1'b0;
    endcase
  end

  // read check of the beat currently on the bus
  always_comb begin
    par_err = 1'b0;
    if (bus_cyc.active && !bus_cyc.write && par_check) begin
      par_err = (lane_parity(addr_data_pins_i[7:0], parity_polarity) !=
                 parity_pin_low_i);
      if (width != ebad_pkg::ebad_width_8) begin
        par_err = par_err || (lane_parity(addr_data_pins_i[15:8],
                  parity_polarity) != parity_pin_high_i);
      end
    end
  end

  // gather read data from bus beats
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rbuf <= 32'h0000_0000;
    end else if (state == ebad_pkg::ebad_idle) begin
      rbuf <= 32'h0000_0000;
    end else if (bus_cyc.active && !bus_cyc.write) begin
      if (width == ebad_pkg::ebad_width_8) begin
        rbuf <= {rbuf[23:0], addr_data_pins_i[7:0]};
      end else if (cpu_req.size == ebad_pkg::ebad_size_byte) begin
        rbuf <= {24'h000000, (cpu_req.addr[0] ? addr_data_pins_i[7:0]
                             : addr_data_pins_i[15:8])};
      end else begin
        rbuf <= {rbuf[15:0], addr_data_pins_i};
      end
    end
  end

  assign cpu_rdata = rbuf;

  assign pcr_value = {parity_error_flag, parity_force_high, parity_polarity,
                      parity_space_sel_hi, parity_space_sel_lo,
                      11'h000};

  // protected registers need a word write
  assign wr_word_ok = reg_bus.wr && reg_bus.word;

  // parity control register and error flag
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      parity_error_flag <= 1'b0;
      pef_seen <= 1'b0;
      parity_force_high <= 1'b0;
      parity_polarity <= 1'b0;
      parity_space_sel_hi <= 1'b0;
      parity_space_sel_lo <= 1'b0;
    end else begin
      if (reg_bus.rd && reg_bus.addr == `EBAD_OFF_PARITY_CTRL &&
          parity_error_flag) begin
        pef_seen <= 1'b1;
      end
      if (reg_bus.wr && reg_bus.addr == `EBAD_OFF_PARITY_CTRL) begin
        parity_force_high <= reg_bus.wdata[`EBAD_PAR_FORCE_BIT];
        parity_polarity <= reg_bus.wdata[`EBAD_PAR_POL_BIT];
        parity_space_sel_hi <= reg_bus.wdata[`EBAD_PAR_SEL_HI_BIT];
        parity_space_sel_lo <= reg_bus.wdata[`EBAD_PAR_SEL_LO_BIT];
        if (!reg_bus.wdata[`EBAD_PAR_ERR_BIT] && pef_seen) begin
          parity_error_flag <= 1'b0;
          pef_seen <= 1'b0;
        end
      end
      if (par_err) parity_error_flag <= 1'b1;
    end
  end

  // bus control register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_control_reg <= `EBAD_BCR_RESET;
    end else if (reg_bus.wr && reg_bus.addr == `EBAD_OFF_BUS_CTRL) begin
      bus_control_reg <= reg_bus.wdata;
    end
  end

  // password protected refresh registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      refresh_control_reg <= `EBAD_RCR_RESET;
      refresh_timer_ctrl_status <= `EBAD_REFRESH_TIMER_CTRL_STATUS_RESET;
      refresh_counter_reg <= `EBAD_REFRESH_COUNTER_REG_RESET;
      refresh_constant_reg <= `EBAD_REFRESH_CONSTANT_REG_RESET;
    end else if (wr_word_ok) begin
      if (reg_bus.addr == `EBAD_OFF_REFRESH_CTRL &&
          reg_bus.wdata[15:8] == `EBAD_PW_RCR) begin
        refresh_control_reg <= reg_bus.wdata[7:0];
      end
      if (reg_bus.addr == `EBAD_OFF_REFRESH_TCS &&
          reg_bus.wdata[15:8] == `EBAD_PW_REFRESH_TIMER_CTRL_STATUS) begin
        refresh_timer_ctrl_status <= reg_bus.wdata[7:0];
      end
      if (reg_bus.addr == `EBAD_OFF_REFRESH_CNT &&
          reg_bus.wdata[15:8] == `EBAD_PW_REFRESH_COUNTER_REG) begin
        refresh_counter_reg <= reg_bus.wdata[7:0];
      end
      if (reg_bus.addr == `EBAD_OFF_REFRESH_CONST &&
          reg_bus.wdata[15:8] == `EBAD_PW_REFRESH_CONSTANT_REG) begin
        refresh_constant_reg <= reg_bus.wdata[7:0];
      end
    end
  end

  // register read data, one cycle after strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_bus.rd) begin
      unique case (reg_bus.addr)
        `EBAD_OFF_PARITY_CTRL: reg_rdata <= pcr_value;
        `EBAD_OFF_BUS_CTRL: reg_rdata <= bus_control_reg;
        `EBAD_OFF_REFRESH_CTRL: reg_rdata <= {8'h00, refresh_control_reg};
        `EBAD_OFF_REFRESH_TCS:
          reg_rdata <= {8'h00, refresh_timer_ctrl_status};
        `EBAD_OFF_REFRESH_CNT: reg_rdata <= {8'h00, refresh_counter_reg};
        `EBAD_OFF_REFRESH_CONST: reg_rdata <= {8'h00, refresh_constant_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : ebad_top

// File: testbench/ebad_assertions.sv
/* port checker for ebad_top: decode, splitting, parity, registers.
   assumes bind onto ebad_top, one clock, reset nrst. */
`timescale 1ns/1ps
module ebad_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire ebad_pkg::ebad_req_t cpu_req,
  input wire logic cpu_onchip,
  input wire ebad_pkg::ebad_cyc_t bus_cyc,
  input wire logic [15:0] addr_data_pins_o,
  input wire logic [15:0] addr_data_pins_oe,
  input wire logic [7:0] area_select_n,
  input wire logic parity_pin_high_o,
  input wire logic parity_pin_low_o,
  input wire logic parity_pins_oe,
  input wire ebad_pkg::ebad_reg_t reg_bus,
  input wire logic [15:0] reg_rdata
);
  logic force_q;
  logic odd_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      force_q <= 1'b0;
      odd_q <= 1'b0;
    end else if (reg_bus.wr && reg_bus.addr == 4'h0) begin
      force_q <= reg_bus.wdata[14];
      odd_q <= reg_bus.wdata[13];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_cs_decode: assert property (
    area_select_n != 8'hFF |->
    ~area_select_n == (8'h01 << bus_cyc.addr[26:24]))
    else $error("chip select not the decoded area");
  a_cs_onchip: assert property (
    cpu_onchip |-> area_select_n == 8'hFF)
    else $error("chip select low for on-chip space");
  a_cs_dram: assert property (
    bus_cyc.active && bus_cyc.dram |-> area_select_n == 8'hFF)
    else $error("chip select low for dram space");
  a_long_split: assert property (
    $rose(cpu_req.valid) && cpu_req.size == ebad_pkg::ebad_size_long
    && cpu_req.addr[27:24] == 4'h2 |=>
    bus_cyc.active [*4] ##1 !bus_cyc.active)
    else $error("long on 8-bit bus not four beats");
  a_oe_narrow: assert property (
    bus_cyc.active && bus_cyc.write && bus_cyc.addr[27:24] == 4'h2
    |-> addr_data_pins_oe == 16'h00FF)
    else $error("8-bit write uses wrong pins");
  a_par_force: assert property (
    parity_pins_oe && force_q |-> parity_pin_high_o && parity_pin_low_o)
    else $error("forced parity not high");
  a_par_gen: assert property (
    parity_pins_oe && !force_q |->
    parity_pin_low_o == (^addr_data_pins_o[7:0] ^ odd_q))
    else $error("low lane parity wrong");
  a_pcr_zero: assert property (
    reg_bus.rd && reg_bus.addr == 4'h0 |=> reg_rdata[10:0] == 11'h0)
    else $error("parity control low bits not zero");
  a_word_read: assert property (
    reg_bus.rd && reg_bus.word && reg_bus.addr inside {[4'h1:4'h4]}
    |=> reg_rdata[15:8] == 8'h00)
    else $error("refresh register upper byte not zero");
  c_long: cover property (bus_cyc.active [*4]);
  c_onchip: cover property (cpu_onchip);
  c_parity: cover property (parity_pins_oe && force_q);
endmodule : ebad_chk

bind ebad_top ebad_chk chk (.clock(clock), .nrst(nrst),
  .cpu_req(cpu_req), .cpu_onchip(cpu_onchip), .bus_cyc(bus_cyc),
  .addr_data_pins_o(addr_data_pins_o),
  .addr_data_pins_oe(addr_data_pins_oe), .area_select_n(area_select_n),
  .parity_pin_high_o(parity_pin_high_o),
  .parity_pin_low_o(parity_pin_low_o), .parity_pins_oe(parity_pins_oe),
  .reg_bus(reg_bus), .reg_rdata(reg_rdata));

// File: testbench/ebad_mem.sv
/* external memory model: byte at x reads x[7:0]^3C, with parity.
   assumes width wired from address as the decoder chooses it. */
`timescale 1ns/1ps
module ebad_mem (
  input wire logic clock,
  input wire ebad_pkg::ebad_cyc_t bus_cyc,
  input wire logic [2:0] boot_mode_pins,
  input wire logic odd,
  input wire logic bad,
  output logic [15:0] rd_data,
  output logic par_hi,
  output logic par_lo
);
  logic [15:0] last = 16'h0;
  logic [7:0] a;
  logic w16;
  always_comb begin
    a = bus_cyc.addr[7:0];
    if (bus_cyc.addr[26:24] == 3'h0)
      w16 = boot_mode_pins == 3'h1;
    else
      w16 = bus_cyc.addr[27] | (bus_cyc.addr[26:24] == 3'h6
        && bus_cyc.addr[14]);
    if (bus_cyc.active && !bus_cyc.write && w16)
      rd_data = {(a & 8'hFE) ^ 8'h3C, (a | 8'h01) ^ 8'h3C};
    else if (bus_cyc.active && !bus_cyc.write)
      rd_data = {~last[15:8], a ^ 8'h3C};
    else
      rd_data = ~last;
    par_hi = ^rd_data[15:8] ^ odd;
    par_lo = ^rd_data[7:0] ^ odd ^ bad;
  end
  always @(posedge clock) last <= rd_data;
endmodule : ebad_mem

// File: testbench/ebad_top_tb.sv
/* self-checking bench for ebad_top.
   assumes ebad_mem on the far side and the bound checker. */
`timescale 1ns/1ps
`include "ebad_cfg.svh"
module ebad_top_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] boot = 3'h0;
  ebad_pkg::ebad_req_t req = '0;
  ebad_pkg::ebad_reg_t rb = '0;
  ebad_pkg::ebad_cyc_t cyc;
  logic done, onchip, ph_o, pl_o, p_oe, ph_i, pl_i;
  logic [31:0] rdata;
  logic [15:0] ado, adoe, adi, rrd;
  logic [7:0] cs_n;
  logic odd = 1'b0;
  logic bad = 1'b0;
  logic rd_d = 1'b0;
  logic [32:0] e;
  logic [32:0] cq[$];
  logic [15:0] rq[$];
  integer seed = 82;
  int error_cnt = 0;
  int tests_run = 0;
  always #25 clock = ~clock;
  ebad_top DUT (.clock(clock), .nrst(nrst), .boot_mode_pins(boot),
    .cpu_req(req), .cpu_done(done), .cpu_rdata(rdata),
    .cpu_onchip(onchip), .bus_cyc(cyc), .addr_data_pins_o(ado),
    .addr_data_pins_oe(adoe), .addr_data_pins_i(adi),
    .area_select_n(cs_n), .parity_pin_high_o(ph_o),
    .parity_pin_low_o(pl_o), .parity_pins_oe(p_oe),
    .parity_pin_high_i(ph_i), .parity_pin_low_i(pl_i), .reg_bus(rb),
    .reg_rdata(rrd));
  ebad_mem mem (.clock(clock), .bus_cyc(cyc), .boot_mode_pins(boot),
    .odd(odd), .bad(bad), .rd_data(adi), .par_hi(ph_i), .par_lo(pl_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  function automatic logic [7:0] pw(input int r);
    case (r)
      1: pw = `EBAD_PW_RCR;
      2: pw = `EBAD_PW_REFRESH_TIMER_CTRL_STATUS;
      3: pw = `EBAD_PW_REFRESH_COUNTER_REG;
      default: pw = `EBAD_PW_REFRESH_CONSTANT_REG;
    endcase
  endfunction : pw
  // beats of one access, 0 for on-chip space
  function automatic int beats(input logic [31:0] ad, input logic [1:0] sz);
    int w;
    case (ad[26:24])
      3'h0: w = boot == 3'h2 ? 0 : (boot == 3'h1 ? 2 : 1);
      3'h5: w = ad[27] ? 2 : 0;
      3'h6: w = (ad[27] | ad[14]) ? 2 : 1;
      3'h7: w = ad[27] ? 0 : 1;
      default: w = ad[27] ? 2 : 1;
    endcase
    if (w == 0)
      return 0;
    return w == 1 ? (1 << sz) : (sz == 2'h2 ? 2 : 1);
  endfunction : beats
  function automatic logic [31:0] exp_data(input logic [7:0] a, input int n);
    exp_data = 32'h0;
    for (int i = 0; i < n; i++)
      exp_data = {exp_data[23:0], (a + 8'(i)) ^ 8'h3C};
  endfunction : exp_data
  task automatic reg_wr(input logic [3:0] ad, input logic [15:0] d,
                        input logic wd);
    @(posedge clock);
    rb.addr <= ad;
    rb.wdata <= d;
    rb.word <= wd;
    rb.wr <= 1'b1;
    @(posedge clock);
    rb.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] ad, input logic [15:0] exp);
    rq.push_back(exp);
    @(posedge clock);
    rb.addr <= ad;
    rb.word <= 1'b1;
    rb.rd <= 1'b1;
    @(posedge clock);
    rb.rd <= 1'b0;
  endtask : reg_rd
  task automatic cpu_acc(input logic [31:0] ad, input logic [1:0] sz,
                         input logic wr);
    int b;
    int n;
    b = beats(ad, sz);
    if (!wr)
      cq.push_back({b != 0, exp_data(ad[7:0], 1 << sz)});
    @(posedge clock);
    req.valid <= 1'b1;
    req.write <= wr;
    req.size <= ebad_pkg::ebad_size_t'(sz);
    req.addr <= ad;
    req.wdata <= $random(seed);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    chk(n, b == 0 ? 2 : b + 1);
    if (n >= 20)
      conclude();
    @(posedge clock);
    req.valid <= 1'b0;
  endtask : cpu_acc
  always @(posedge clock) begin
    if (rd_d)
      chk({16'h0, rrd}, {16'h0, rq.pop_front()});
    rd_d <= rb.rd;
    if (done === 1'b1 && req.write === 1'b0 && cq.size() > 0) begin
      e = cq.pop_front();
      if (e[32])
        chk(rdata, e[31:0]);
    end
  end
  initial begin
    logic [31:0] ad;
    logic [7:0] v;
    logic [1:0] sz;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (int r = 0; r < 7; r++)
      reg_rd(4'(r), r == 4 ? 16'h00FF : 16'h0000);
    note("reset");
    for (int r = 1; r < 5; r++) begin
      v = 8'($random(seed));
      reg_wr(4'(r), {pw(r), v}, 1'b0);
      reg_wr(4'(r), {~pw(r), ~v}, 1'b1);
      reg_rd(4'(r), r == 4 ? 16'h00FF : 16'h0000);
      reg_wr(4'(r), {pw(r), v}, 1'b1);
      reg_rd(4'(r), {8'h00, v});
    end
    note("protect");
    for (int b = 0; b < 3; b++) begin
      boot <= 3'(b);
      @(posedge clock);
      for (int k = 0; k < 48; k++) begin
        ad = $random(seed);
        ad[27:24] = 4'(k % 16);
        sz = 2'(k / 16);
        if (sz != 2'h0)
          ad[0] = 1'b0;
        if (sz == 2'h2)
          ad[1] = 1'b0;
        if (!(ad[27:24] == 4'h5 && sz == 2'h2 && !ad[8]))
          cpu_acc(ad, sz, ad[31]);
      end
    end
    note("decode");
    reg_wr(4'h0, 16'h7FFF, 1'b1);
    reg_rd(4'h0, 16'h7800);
    reg_wr(4'h0, 16'h5000, 1'b1);
    cpu_acc(32'h0200_0010, 2'h2, 1'b1);
    reg_wr(4'h0, 16'h3000, 1'b1);
    cpu_acc(32'h0200_0020, 2'h2, 1'b1);
    odd <= 1'b1;
    cpu_acc(32'h0A00_0040, 2'h2, 1'b0);
    reg_rd(4'h0, 16'h3000);
    odd <= 1'b0;
    cpu_acc(32'h0A00_0040, 2'h1, 1'b0);
    reg_wr(4'h0, 16'h3000, 1'b1);
    reg_rd(4'h0, 16'hB000);
    reg_wr(4'h0, 16'h3000, 1'b1);
    reg_rd(4'h0, 16'h3000);
    bad <= 1'b1;
    reg_wr(4'h0, 16'h0800, 1'b1);
    reg_wr(4'h5, 16'h8000, 1'b1);
    cpu_acc(32'h0200_0000, 2'h1, 1'b0);
    reg_rd(4'h0, 16'h0800);
    cpu_acc(32'h0100_0000, 2'h1, 1'b0);
    reg_rd(4'h0, 16'h8800);
    note("parity");
    conclude();
  end
endmodule : ebad_top_tb
